// ---- logic/dcw_cycle_decode.sv ----
// Purpose: Decodes a host cycle onto one register of the bank.
// Assumes: MMIO base comes from the graphics configuration space.
// Notes: Purely combinational; the top registers its result.
`timescale 1ns/10ps
module dcw_cycle_decode (
    // Cycle
    input wire logic cyc_io_i,
    input wire logic cyc_write_i,
    input wire logic [dcw_pkg::ADDR_W-1:0] cyc_addr_i,
    // Base
    input wire logic [dcw_pkg::ADDR_W-1:0] mmio_base_i,
    // Result
    output dcw_pkg::dcw_sel_t sel_o
);
    import dcw_pkg::*;

    logic [ADDR_W-1:0] offset;
    logic [IO_W-1:0] reg_addr;
    logic in_range;

    always_comb begin
        // I/O space is 64K wide; memory space is relative to the base
        offset = cyc_addr_i - mmio_base_i;
        if (cyc_io_i) begin
            reg_addr = cyc_addr_i[IO_W-1:0];
            in_range = 1'b1;
        end else begin
            reg_addr = offset[IO_W-1:0];
            in_range = (offset[ADDR_W-1:IO_W] == '0);
        end
        sel_o = DCW_SEL_NONE;
        if (in_range) begin
            // Misc output has split write and read addresses
            if (cyc_write_i && reg_addr == IO_MISC_WR) begin
                sel_o = DCW_SEL_MISC_WR;
            end else if (!cyc_write_i && reg_addr == IO_MISC_RD) begin
                sel_o = DCW_SEL_MISC_RD;
            end else if (reg_addr == IO_GR_INDEX) begin
                sel_o = DCW_SEL_INDEX;
            end else if (reg_addr == IO_GR_DATA) begin
                sel_o = DCW_SEL_DATA;
            end
        end
    end
endmodule : dcw_cycle_decode

// ---- logic/dcw_pkg.sv ----
// Function
// - Bank answers both I/O and memory cycles
// - Memory address is base plus I/O address
// - Full index byte selects data-port register
// - Index upper nibble reads back zero
// - Misc output written 3C2h, read 3CCh
// - Misc bit 1 enables legacy window access
// - Window disabled: legacy cycles are not claimed
// - Window bit ignores linear frame buffer
// - Map mode field places the window
// - Map mode applies only while paging is off
// - Address mapping bit 4 steers paging target
// - Bits 3..1 select map, packed, linear
// - Bit 0 pages through A0000h window
// - Page select picks 64 KB cache window
//
// Purpose: Constants for the display cache legacy window registers.
// Assumes: Host cycles arrive on the system clock.
// Notes: I/O addresses double as memory offsets from the MMIO base.
package dcw_pkg;
    localparam int ADDR_W = 32;
    localparam int IO_W = 16;
    localparam int DATA_W = 8;
    localparam int PAGE_SHIFT = 16;

    // Register addresses, I/O space and MMIO offset alike
    localparam logic [IO_W-1:0] IO_MISC_WR = 16'h03C2;
    localparam logic [IO_W-1:0] IO_MISC_RD = 16'h03CC;
    localparam logic [IO_W-1:0] IO_GR_INDEX = 16'h03CE;
    localparam logic [IO_W-1:0] IO_GR_DATA = 16'h03CF;

    // Indexed registers behind the data port
    localparam logic [DATA_W-1:0] GR_IDX_MAP_MODE = 8'h06;
    localparam logic [DATA_W-1:0] GR_IDX_ADDR_MAP = 8'h10;
    localparam logic [DATA_W-1:0] GR_IDX_PAGE = 8'h11;

    // Reset values
    localparam logic [DATA_W-1:0] MISC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] INDEX_RESET = 8'h00;
    localparam logic [DATA_W-1:0] MAP_MODE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ADDR_MAP_RESET = 8'h00;
    localparam logic [DATA_W-1:0] PAGE_RESET = 8'h00;

    // Implemented bits; the rest read as zero
    localparam logic [DATA_W-1:0] MISC_MASK = 8'h02;
    localparam logic [DATA_W-1:0] INDEX_RD_MASK = 8'h0F;
    localparam logic [DATA_W-1:0] MAP_MODE_MASK = 8'h0C;
    localparam logic [DATA_W-1:0] ADDR_MAP_MASK = 8'h1F;
    localparam logic [DATA_W-1:0] PAGE_MASK = 8'hFF;

    // Field positions
    localparam int MISC_WIN_EN_BIT = 1;
    localparam int MAP_MODE_LSB = 2;
    localparam int AM_PAGE_CACHE_BIT = 4;
    localparam int AM_MEM_MAP_BIT = 3;
    localparam int AM_PACKED_BIT = 2;
    localparam int AM_LINEAR_BIT = 1;
    localparam int AM_PAGE_EN_BIT = 0;

    // Memory map mode encodings
    localparam logic [1:0] MODE_A0_128K = 2'b00;
    localparam logic [1:0] MODE_A0_64K = 2'b01;
    localparam logic [1:0] MODE_B0_32K = 2'b10;
    localparam logic [1:0] MODE_B8_32K = 2'b11;

    // Legacy window bounds, end exclusive
    localparam logic [ADDR_W-1:0] WIN_A0000 = 32'h000A_0000;
    localparam logic [ADDR_W-1:0] WIN_B0000 = 32'h000B_0000;
    localparam logic [ADDR_W-1:0] WIN_B8000 = 32'h000B_8000;
    localparam logic [ADDR_W-1:0] WIN_C0000 = 32'h000C_0000;

    typedef enum logic [2:0] {
        DCW_SEL_NONE,
        DCW_SEL_MISC_WR,
        DCW_SEL_MISC_RD,
        DCW_SEL_INDEX,
        DCW_SEL_DATA
    } dcw_sel_t;
endpackage : dcw_pkg

// ---- logic/dcw_regs.sv ----
// Purpose: Display cache detect and legacy window register bank.
// Assumes: Host cycle strobes come from logic on clk_sys_i.
// Notes: One cycle from request to answer; answers are registered.
`timescale 1ns/10ps
module dcw_regs #(
    parameter int CACHE_AW = 24
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Host cycle
    input wire logic cyc_valid_i,
    input wire logic cyc_io_i,
    input wire logic cyc_write_i,
    input wire logic [dcw_pkg::ADDR_W-1:0] cyc_addr_i,
    input wire logic [dcw_pkg::DATA_W-1:0] cyc_wdata_i,
    // Configuration
    input wire logic [dcw_pkg::ADDR_W-1:0] mmio_base_i,
    // Register answer
    output logic reg_claim_o,
    output logic rd_valid_o,
    output logic [dcw_pkg::DATA_W-1:0] rd_data_o,
    // Legacy window answer
    output logic fb_claim_o,
    output logic fb_to_cache_o,
    output logic [CACHE_AW-1:0] fb_cache_addr_o,
    // Control state
    output logic win_access_en_o,
    output logic [1:0] map_mode_o,
    output logic mem_map_sel_o,
    output logic packed_en_o,
    output logic linear_en_o,
    output logic page_map_en_o,
    output logic [dcw_pkg::DATA_W-1:0] page_select_o
);
    import dcw_pkg::*;

    // Register state
    logic [DATA_W-1:0] gr_index;
    logic [DATA_W-1:0] misc_output_reg;
    logic [DATA_W-1:0] map_mode_reg;
    logic [DATA_W-1:0] address_mapping_reg;
    logic [DATA_W-1:0] page_selector_reg;
    logic [DATA_W-1:0] next_gr_index;
    logic [DATA_W-1:0] next_misc_output_reg;
    logic [DATA_W-1:0] next_map_mode_reg;
    logic [DATA_W-1:0] next_address_mapping_reg;
    logic [DATA_W-1:0] next_page_selector_reg;

    // Answer state
    logic next_reg_claim;
    logic next_rd_valid;
    logic [DATA_W-1:0] next_rd_data;
    logic next_fb_claim;
    logic next_fb_to_cache;
    logic [CACHE_AW-1:0] next_fb_cache_addr;

    // Decode results
    dcw_sel_t sel;
    logic in_win;
    logic [CACHE_AW-1:0] win_cache_addr;
    logic win_en;
    logic page_en;
    logic page_to_cache;

    // Write strobes, one per stored register
    logic wr_misc;
    logic wr_index;
    logic wr_map_mode;
    logic wr_addr_map;
    logic wr_page;

    // Read strobes, one per answering register
    logic rd_misc;
    logic rd_index;
    logic rd_data_port;

    // Cycle hits
    logic reg_hit;
    logic win_hit;

    // Keeps reserved bits at zero on reads and on every write except the index
    function automatic logic [DATA_W-1:0] masked(
        input logic [DATA_W-1:0] value,
        input logic [DATA_W-1:0] mask
    );
        masked = value & mask;
    endfunction : masked

    // Reads the register that the index points at
    function automatic logic [DATA_W-1:0] gr_read(
        input logic [DATA_W-1:0] idx,
        input logic [DATA_W-1:0] mm,
        input logic [DATA_W-1:0] am,
        input logic [DATA_W-1:0] pg
    );
        case (idx)
            GR_IDX_MAP_MODE: begin
                gr_read = masked(mm, MAP_MODE_MASK);
            end
            GR_IDX_ADDR_MAP: begin
                gr_read = masked(am, ADDR_MAP_MASK);
            end
            GR_IDX_PAGE: begin
                gr_read = masked(pg, PAGE_MASK);
            end
            default: begin
                gr_read = '0;
            end
        endcase
    endfunction : gr_read

    // True when the data port points at the given indexed register
    function automatic logic gr_sel(
        input logic [DATA_W-1:0] idx,
        input logic [DATA_W-1:0] code
    );
        gr_sel = (idx == code);
    endfunction : gr_sel

    // Paged cycles follow the steering bit; unpaged ones reach the cache
    function automatic logic steer_to_cache(
        input logic paged,
        input logic steer
    );
        steer_to_cache = paged ? steer : 1'b1;
    endfunction : steer_to_cache

    dcw_cycle_decode u_decode (
        .cyc_io_i(cyc_io_i),
        .cyc_write_i(cyc_write_i),
        .cyc_addr_i(cyc_addr_i),
        .mmio_base_i(mmio_base_i),
        .sel_o(sel)
    );

    dcw_window_map #(
        .CACHE_AW(CACHE_AW)
    ) u_window (
        .addr_i(cyc_addr_i),
        .map_mode_i(map_mode_reg[MAP_MODE_LSB +: 2]),
        .page_en_i(page_en),
        .page_i(page_selector_reg),
        .in_win_o(in_win),
        .cache_addr_o(win_cache_addr)
    );

    assign win_en = misc_output_reg[MISC_WIN_EN_BIT];
    assign page_en = address_mapping_reg[AM_PAGE_EN_BIT];
    assign page_to_cache = address_mapping_reg[AM_PAGE_CACHE_BIT];

    // Cycle strobes; a register hit wins over a window hit
    always_comb begin
        wr_misc = 1'b0;
        wr_index = 1'b0;
        wr_map_mode = 1'b0;
        wr_addr_map = 1'b0;
        wr_page = 1'b0;
        rd_misc = 1'b0;
        rd_index = 1'b0;
        rd_data_port = 1'b0;
        reg_hit = cyc_valid_i && (sel != DCW_SEL_NONE);
        // I/O cycles never reach the legacy window
        win_hit = cyc_valid_i && !reg_hit && !cyc_io_i && in_win;
        if (cyc_valid_i) begin
            case (sel)
                DCW_SEL_MISC_WR: begin
                    wr_misc = cyc_write_i;
                end
                DCW_SEL_MISC_RD: begin
                    rd_misc = !cyc_write_i;
                end
                DCW_SEL_INDEX: begin
                    wr_index = cyc_write_i;
                    rd_index = !cyc_write_i;
                end
                DCW_SEL_DATA: begin
                    // Unknown indices are claimed but change nothing
                    wr_map_mode = cyc_write_i
                        && gr_sel(gr_index, GR_IDX_MAP_MODE);
                    wr_addr_map = cyc_write_i
                        && gr_sel(gr_index, GR_IDX_ADDR_MAP);
                    wr_page = cyc_write_i
                        && gr_sel(gr_index, GR_IDX_PAGE);
                    rd_data_port = !cyc_write_i;
                end
                default: begin
                    rd_misc = 1'b0;
                end
            endcase
        end
    end

    // Register writes
    always_comb begin
        next_gr_index = gr_index;
        next_misc_output_reg = misc_output_reg;
        next_map_mode_reg = map_mode_reg;
        next_address_mapping_reg = address_mapping_reg;
        next_page_selector_reg = page_selector_reg;
        if (wr_misc) begin
            next_misc_output_reg =
                masked(cyc_wdata_i, MISC_MASK);
        end
        if (wr_index) begin
            // Full byte kept so indices 10h and 11h are reachable
            next_gr_index = cyc_wdata_i;
        end
        if (wr_map_mode) begin
            next_map_mode_reg =
                masked(cyc_wdata_i, MAP_MODE_MASK);
        end
        if (wr_addr_map) begin
            next_address_mapping_reg =
                masked(cyc_wdata_i, ADDR_MAP_MASK);
        end
        if (wr_page) begin
            next_page_selector_reg =
                masked(cyc_wdata_i, PAGE_MASK);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            gr_index <= INDEX_RESET;
            misc_output_reg <= MISC_RESET;
            map_mode_reg <= MAP_MODE_RESET;
            address_mapping_reg <= ADDR_MAP_RESET;
            page_selector_reg <= PAGE_RESET;
        end else begin
            gr_index <= next_gr_index;
            misc_output_reg <= next_misc_output_reg;
            map_mode_reg <= next_map_mode_reg;
            address_mapping_reg <= next_address_mapping_reg;
            page_selector_reg <= next_page_selector_reg;
        end
    end

    // Register answers
    always_comb begin
        next_reg_claim = reg_hit;
        next_rd_valid = reg_hit && !cyc_write_i;
        next_rd_data = '0;
        if (rd_misc) begin
            next_rd_data = masked(misc_output_reg, MISC_MASK);
        end
        if (rd_index) begin
            next_rd_data = masked(gr_index, INDEX_RD_MASK);
        end
        if (rd_data_port) begin
            next_rd_data = gr_read(gr_index, map_mode_reg,
                address_mapping_reg, page_selector_reg);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            reg_claim_o <= 1'b0;
            rd_valid_o <= 1'b0;
            rd_data_o <= '0;
        end else begin
            reg_claim_o <= next_reg_claim;
            rd_valid_o <= next_rd_valid;
            rd_data_o <= next_rd_data;
        end
    end

    // Window answers
    always_comb begin
        next_fb_claim = 1'b0;
        next_fb_to_cache = 1'b0;
        next_fb_cache_addr = '0;
        // Only the legacy window is gated here; linear frame buffer
        // cycles never reach this decode
        if (win_hit && win_en) begin
            next_fb_claim = 1'b1;
            next_fb_cache_addr = win_cache_addr;
            next_fb_to_cache =
                steer_to_cache(page_en, page_to_cache);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            fb_claim_o <= 1'b0;
            fb_to_cache_o <= 1'b0;
            fb_cache_addr_o <= '0;
        end else begin
            fb_claim_o <= next_fb_claim;
            fb_to_cache_o <= next_fb_to_cache;
            fb_cache_addr_o <= next_fb_cache_addr;
        end
    end

    // Control outputs follow the registers
    always_comb begin
        win_access_en_o = win_en;
        map_mode_o = map_mode_reg[MAP_MODE_LSB +: 2];
        mem_map_sel_o = address_mapping_reg[AM_MEM_MAP_BIT];
        packed_en_o = address_mapping_reg[AM_PACKED_BIT];
        linear_en_o = address_mapping_reg[AM_LINEAR_BIT];
        page_map_en_o = page_en;
        page_select_o = page_selector_reg;
    end
endmodule : dcw_regs

// ---- logic/dcw_window_map.sv ----
// Purpose: Maps a legacy window address onto the display cache.
// Assumes: Linear frame buffer decode lives elsewhere.
// Notes: Purely combinational; the top registers its result.
`timescale 1ns/10ps
module dcw_window_map #(
    parameter int CACHE_AW = 24
) (
    // Cycle
    input wire logic [dcw_pkg::ADDR_W-1:0] addr_i,
    // Controls
    input wire logic [1:0] map_mode_i,
    input wire logic page_en_i,
    input wire logic [dcw_pkg::DATA_W-1:0] page_i,
    // Result
    output logic in_win_o,
    output logic [CACHE_AW-1:0] cache_addr_o
);
    import dcw_pkg::*;

    logic [ADDR_W-1:0] lo;
    logic [ADDR_W-1:0] hi;
    logic [ADDR_W-1:0] rel;

    always_comb begin
        // Paging always uses the 64 KB window at A0000h
        if (page_en_i) begin
            lo = WIN_A0000;
            hi = WIN_B0000;
        end else begin
            case (map_mode_i)
                MODE_A0_128K: begin lo = WIN_A0000; hi = WIN_C0000; end
                MODE_A0_64K: begin lo = WIN_A0000; hi = WIN_B0000; end
                MODE_B0_32K: begin lo = WIN_B0000; hi = WIN_B8000; end
                default: begin lo = WIN_B8000; hi = WIN_C0000; end
            endcase
        end
        rel = addr_i - lo;
        in_win_o = (addr_i >= lo) && (addr_i < hi);
        if (page_en_i) begin
            cache_addr_o = CACHE_AW'({page_i, rel[PAGE_SHIFT-1:0]});
        end else begin
            cache_addr_o = CACHE_AW'(rel);
        end
    end
endmodule : dcw_window_map

// ---- verif/dcw_regs_asserts.sv ----
// Purpose: Port checks for the legacy window register bank.
// Assumes: The MMIO base sits above the window and the linear range.
// Notes: Register hits are kept away from window addresses.
`timescale 1ns/10ps
module dcw_regs_asserts #(
    parameter int CACHE_AW = 24
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Host cycle
    input wire logic cyc_valid_i,
    input wire logic cyc_io_i,
    input wire logic cyc_write_i,
    input wire logic [31:0] cyc_addr_i,
    // Answers
    input wire logic reg_claim_o,
    input wire logic rd_valid_o,
    input wire logic [7:0] rd_data_o,
    input wire logic fb_claim_o,
    input wire logic fb_to_cache_o,
    input wire logic [CACHE_AW-1:0] fb_cache_addr_o,
    input wire logic win_access_en_o,
    input wire logic [1:0] map_mode_o,
    input wire logic page_map_en_o,
    input wire logic [7:0] page_select_o
);
    wire logic io_rd = cyc_valid_i && cyc_io_i && !cyc_write_i;
    wire logic mem_win = cyc_valid_i && !cyc_io_i
        && cyc_addr_i >= 32'h000A_0000 && cyc_addr_i < 32'h000C_0000;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    AST_MISC_READ:
    assert property (io_rd && cyc_addr_i[15:0] == 16'h03CC |=> reg_claim_o
        && rd_valid_o && rd_data_o == {6'h00, win_access_en_o, 1'b0})
        else $error("misc read answer wrong");
    AST_MISC_WRONLY:
    assert property (io_rd && cyc_addr_i[15:0] == 16'h03C2
        |=> !reg_claim_o && !rd_valid_o) else $error("misc write port read");
    AST_INDEX_HIGH:
    assert property (io_rd && cyc_addr_i[15:0] == 16'h03CE
        |=> rd_valid_o && rd_data_o[7:4] == 4'h0)
        else $error("index upper bits not zero");
    AST_BLOCKED:
    assert property (mem_win && !win_access_en_o |=> !fb_claim_o)
        else $error("window claimed while disabled");
    AST_LINEAR:
    assert property (cyc_valid_i && !cyc_io_i && cyc_addr_i >= 32'h000C_0000
        && cyc_addr_i < 32'h8000_0000 |=> !fb_claim_o)
        else $error("linear address claimed");
    AST_MODE_FULL:
    assert property (mem_win && win_access_en_o && !page_map_en_o
        && map_mode_o == 2'b00 |=> fb_claim_o && fb_to_cache_o
        && fb_cache_addr_o == CACHE_AW'($past(cyc_addr_i) - 32'h000A_0000))
        else $error("full window target wrong");
    AST_MODE_B8:
    assert property (mem_win && !page_map_en_o && map_mode_o == 2'b11
        && cyc_addr_i < 32'h000B_8000 |=> !fb_claim_o)
        else $error("mode 3 claimed below B8000");
    AST_PAGE_ADDR:
    assert property (mem_win && win_access_en_o && page_map_en_o
        && cyc_addr_i < 32'h000B_0000 |=> fb_claim_o
        && fb_cache_addr_o == CACHE_AW'({$past(page_select_o), 16'h0000}
        | ($past(cyc_addr_i) & 32'h0000_FFFF)))
        else $error("paged target wrong");
    AST_PAGE_HIGH:
    assert property (mem_win && page_map_en_o && cyc_addr_i >= 32'h000B_0000
        |=> !fb_claim_o) else $error("paging claimed above AFFFF");
endmodule : dcw_regs_asserts

// ---- verif/test_dcw_regs.sv ----
// Purpose: Directed test of the legacy window register bank.
// Assumes: Base sits high so register hits never meet the window.
// Notes: Inputs change on the falling edge; answers are read there.
`timescale 1ns/10ps
module test_dcw_regs;
    import dcw_pkg::*;
    localparam logic [31:0] BASE = 32'h8000_0000;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_valid_i = 1'b0;
    logic cyc_io_i = 1'b0;
    logic cyc_write_i = 1'b0;
    logic [31:0] cyc_addr_i = 32'h0000_0000;
    logic [7:0] cyc_wdata_i = 8'h00;
    logic reg_claim_o, rd_valid_o, fb_claim_o, fb_to_cache_o;
    logic [7:0] rd_data_o, page_select_o;
    logic [23:0] fb_cache_addr_o;
    logic win_access_en_o, mem_map_sel_o, packed_en_o, linear_en_o;
    logic page_map_en_o;
    logic [1:0] map_mode_o;
    int mismatches = 0;
    int n_compared = 0;
    logic [7:0] idx [3] = '{8'h06, 8'h10, 8'h11};
    logic [7:0] msk [3] = '{8'h0C, 8'h1F, 8'hFF};
    logic [31:0] st [4] = '{32'hA0000, 32'hA0000, 32'hB0000, 32'hB8000};
    logic [31:0] en [4] = '{32'hC0000, 32'hB0000, 32'hB8000, 32'hC0000};
    logic [31:0] ta [3] = '{32'hA1234, 32'hB1234, 32'hB9234};

    always #5 clk_sys_i = ~clk_sys_i;

    dcw_regs #(.CACHE_AW(24)) uut (.clk_sys_i, .rst_i, .cyc_valid_i,
        .cyc_io_i, .cyc_write_i, .cyc_addr_i, .cyc_wdata_i,
        .mmio_base_i(BASE), .reg_claim_o, .rd_valid_o, .rd_data_o,
        .fb_claim_o, .fb_to_cache_o, .fb_cache_addr_o, .win_access_en_o,
        .map_mode_o, .mem_map_sel_o, .packed_en_o, .linear_en_o,
        .page_map_en_o, .page_select_o);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask : chk

    // One request, held over one rising edge; the answer stands after it
    task automatic cyc(input logic io, input logic w, input logic [31:0] a,
                       input logic [7:0] d);
        @(negedge clk_sys_i);
        cyc_valid_i = 1'b1;
        cyc_io_i = io;
        cyc_write_i = w;
        cyc_addr_i = a;
        cyc_wdata_i = d;
        @(negedge clk_sys_i);
        cyc_valid_i = 1'b0;
    endtask : cyc

    task automatic wr(input logic io, input logic [15:0] a,
                      input logic [7:0] d);
        cyc(io, 1'b1, io ? {16'h0000, a} : BASE + 32'(a), d);
        chk(32'(reg_claim_o), 32'h1, "write claim");
    endtask : wr

    task automatic rd(input logic io, input logic [15:0] a,
                      input logic [7:0] exp);
        cyc(io, 1'b0, io ? {16'h0000, a} : BASE + 32'(a), 8'h00);
        chk(32'({rd_valid_o, rd_data_o}), 32'({1'b1, exp}), "read");
    endtask : rd

    task automatic gw(input logic [7:0] i, input logic [7:0] d);
        wr(1'b1, IO_GR_INDEX, i);
        wr(1'b1, IO_GR_DATA, d);
    endtask : gw

    task automatic gr(input logic [7:0] i, input logic [7:0] exp);
        wr(1'b1, IO_GR_INDEX, i);
        rd(1'b1, IO_GR_DATA, exp);
    endtask : gr

    task automatic win(input logic [31:0] a, input logic c, input logic t,
                       input logic [23:0] ca);
        cyc(1'b0, 1'b0, a, 8'h00);
        chk(32'({fb_claim_o, reg_claim_o}), 32'({c, 1'b0}), "window claim");
        if (c) begin
            chk(32'({fb_to_cache_o, fb_cache_addr_o}), 32'({t, ca}), "target");
        end
    endtask : win

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (2) @(negedge clk_sys_i);
        rst_i = 1'b0;
        rd(1'b1, IO_MISC_RD, 8'h00);
        gr(8'h06, 8'h00);
        gr(8'h10, 8'h00);
        gr(8'h11, 8'h00);
        $display("test reset_values done");
        wr(1'b1, IO_MISC_WR, 8'hFF);
        rd(1'b0, IO_MISC_RD, 8'h02);
        chk(32'(win_access_en_o), 32'h1, "window enable");
        cyc(1'b1, 1'b0, 32'(IO_MISC_WR), 8'h00);
        chk(32'({reg_claim_o, rd_valid_o}), 32'h0, "write port read");
        cyc(1'b1, 1'b0, 32'h0000_03C0, 8'h00);
        chk(32'(reg_claim_o), 32'h0, "unmapped claim");
        wr(1'b0, IO_GR_INDEX, 8'h16);
        rd(1'b1, IO_GR_INDEX, 8'h06);
        rd(1'b0, IO_GR_DATA, 8'h00);
        $display("test access_paths done");
        for (int i = 0; i < 3; i++) begin
            gw(idx[i], 8'hFF);
            gr(idx[i], msk[i]);
        end
        chk(32'({map_mode_o, mem_map_sel_o, packed_en_o, linear_en_o,
            page_map_en_o, page_select_o}), 32'h3FFF, "controls");
        $display("test field_masks done");
        gw(8'h10, 8'h00);
        for (int m = 0; m < 4; m++) begin
            gw(8'h06, 8'(m << 2));
            for (int j = 0; j < 3; j++) begin
                win(ta[j], ta[j] >= st[m] && ta[j] < en[m], 1'b1,
                    24'(ta[j] - st[m]));
            end
        end
        win(32'h0010_0000, 1'b0, 1'b0, 24'h0);
        wr(1'b1, IO_MISC_WR, 8'h00);
        win(32'h000B_9234, 1'b0, 1'b0, 24'h0);
        $display("test window_modes done");
        wr(1'b1, IO_MISC_WR, 8'h02);
        gw(8'h11, 8'h05);
        gw(8'h10, 8'h01);
        win(32'h000A_1234, 1'b1, 1'b0, 24'h05_1234);
        win(32'h000B_9234, 1'b0, 1'b0, 24'h0);
        gw(8'h10, 8'h11);
        gw(8'h11, 8'hFF);
        win(32'h000A_FFFF, 1'b1, 1'b1, 24'hFF_FFFF);
        $display("test paging done");
        @(negedge clk_sys_i);
        rst_i = 1'b1;
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        chk(32'({win_access_en_o, page_map_en_o, page_select_o}), 32'h0,
            "reset state");
        rd(1'b1, IO_MISC_RD, 8'h00);
        $display("test mid_reset done");
        end_of_test();
    end
endmodule : test_dcw_regs

bind dcw_regs dcw_regs_asserts #(.CACHE_AW(CACHE_AW)) u_chk (.clk_sys_i,
    .rst_i, .cyc_valid_i, .cyc_io_i, .cyc_write_i, .cyc_addr_i,
    .reg_claim_o, .rd_valid_o, .rd_data_o, .fb_claim_o, .fb_to_cache_o,
    .fb_cache_addr_o, .win_access_en_o, .map_mode_o, .page_map_en_o,
    .page_select_o);
